/* File: logic/arfc_pkg.sv */
// Constants, field layouts and carrier types for the acquisition result buffer.
// Assumes byte-addressed 32-bit register accesses and a converter tag stream.
package arfc_pkg;
  localparam logic [7:0] OFS_DIV = 8'h10;
  localparam logic [7:0] OFS_DIV2 = 8'h14;
  localparam logic [7:0] OFS_THR = 8'h20;
  localparam logic [7:0] OFS_CNT = 8'h28;
  localparam logic [7:0] OFS_DATA = 8'h30;
  localparam logic [7:0] OFS_CTRL = 8'h38;
  localparam logic [7:0] OFS_STAT = 8'h40;

  // Control register fields.
  localparam int CTL_SCAN = 18;
  localparam int CTL_CFG = 17;
  localparam int CTL_GO = 16;
  localparam int CTL_LAST_LO = 12;
  localparam logic [31:0] CTL_RW_MASK = 32'h0004_7bfa;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;

  // Status register fields, write one to clear.
  localparam int STAT_OVR = 21;
  localparam int STAT_AF = 20;

  // Buffer word fields.
  localparam int W_INVALID = 31;
  localparam int W_RUN = 30;
  localparam int W_PIN_LO = 28;
  localparam int W_TEMP = 25;
  localparam int W_MUX = 24;
  localparam int W_SEL = 23;
  localparam int W_CH_LO = 20;
  localparam int W_DIFF = 19;
  localparam int W_GAIN_LO = 16;
  localparam logic [31:0] INVALID_WORD = 32'h8000_0000;

  typedef struct packed {
    logic temp;
    logic mux;
    logic conv_sel;
    logic [2:0] channel;
    logic diff;
    logic [2:0] range_code;
    logic [15:0] result;
  } arfc_sample_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } arfc_reg_req_t;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b01,
    SEQ_SCAN = 2'b10
  } arfc_seq_t;
endpackage : arfc_pkg

/* File: logic/arfc_buffer_mem.sv */
// Simple dual-port storage for the result buffer, one write and one read port.
// Read data come out of a register one clock after the address; no reset on contents.
`timescale 1ns/10ps
module arfc_buffer_mem #(
  parameter int WIDTH = 64,
  parameter int AW = 12
) (
  input wire logic i_core_clk,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [WIDTH-1:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [WIDTH-1:0] o_rdata
);
  logic [WIDTH-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge i_core_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_core_clk) begin
    o_rdata <= mem[i_raddr];
  end
endmodule : arfc_buffer_mem

/* File: logic/arfc_top.sv */
// Acquisition result buffer and primary acquisition control.
// Assumes one outstanding conversion at a time and synchronous register requests.
`timescale 1ns/10ps
module arfc_top #(
  parameter int AW = 12
) (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire arfc_pkg::arfc_reg_req_t i_reg_req,
  output logic [31:0] o_reg_rdata,
  output logic o_reg_rvalid,
  input wire logic i_dma_req,
  output logic [63:0] o_dma_data,
  output logic o_dma_valid,
  input wire logic i_smp_valid,
  input wire arfc_pkg::arfc_sample_t i_smp,
  output logic o_smp_ready,
  input wire logic [1:0] i_pin_snapshot,
  output logic o_conv_start,
  output logic [2:0] o_conv_channel,
  output logic [15:0] o_cfg_word,
  output logic o_cfg_strobe,
  output logic o_almost_full,
  output logic o_overrun
);
  localparam logic [AW-1:0] MAX_CNT = {AW{1'b1}};
  function automatic logic [31:0] build_word(input arfc_pkg::arfc_sample_t s,
                                             input logic [1:0] pins, input logic run);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[15:0] = s.result;
    w[arfc_pkg::W_RUN] = run;
    w[arfc_pkg::W_PIN_LO +: 2] = pins;
    w[arfc_pkg::W_TEMP] = s.temp;
    w[arfc_pkg::W_MUX] = s.mux;
    w[arfc_pkg::W_SEL] = s.conv_sel;
    w[arfc_pkg::W_CH_LO +: 3] = s.channel;
    w[arfc_pkg::W_DIFF] = s.diff;
    w[arfc_pkg::W_GAIN_LO +: 3] = s.range_code;
    return w;
  endfunction : build_word
  function automatic logic hit(input arfc_pkg::arfc_reg_req_t r, input logic [7:0] ofs);
    return r.addr == ofs;
  endfunction : hit
  logic [31:0] div_q, div2_q, ctrl_q, rate_cnt_q, gap_cnt_q;
  logic [11:0] thr_q;
  logic running_q, go_q, wide;
  logic [2:0] scan_ch_q;
  logic [1:0] pins_q;
  arfc_pkg::arfc_seq_t seq_q;
  logic wr_div, wr_ctrl, host_rd_data, start_event, tick;
  assign wide = div_q != 32'h0000_0000;
  assign wr_div = i_reg_req.wr && hit(i_reg_req, arfc_pkg::OFS_DIV);
  assign wr_ctrl = i_reg_req.wr && hit(i_reg_req, arfc_pkg::OFS_CTRL);
  assign host_rd_data = i_reg_req.rd && hit(i_reg_req, arfc_pkg::OFS_DATA);
  // Configuration registers.
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      div_q <= 32'h0000_0000;
      div2_q <= 32'h0000_0000;
      thr_q <= 12'h000;
      ctrl_q <= arfc_pkg::CTL_RESET;
    end else if (i_reg_req.wr) begin
      if (wr_div) div_q <= i_reg_req.wdata;
      if (hit(i_reg_req, arfc_pkg::OFS_DIV2)) div2_q <= i_reg_req.wdata;
      if (hit(i_reg_req, arfc_pkg::OFS_THR)) thr_q <= i_reg_req.wdata[11:0];
      if (wr_ctrl) ctrl_q <= i_reg_req.wdata & arfc_pkg::CTL_RW_MASK;
    end
  end
  // One-shot commands; launch acts a cycle later so it sees the stored fields.
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      go_q <= 1'b0;
      o_cfg_strobe <= 1'b0;
      o_cfg_word <= 16'h0000;
    end else begin
      go_q <= wr_ctrl && i_reg_req.wdata[arfc_pkg::CTL_GO];
      o_cfg_strobe <= wr_ctrl && i_reg_req.wdata[arfc_pkg::CTL_CFG];
      if (wr_ctrl && i_reg_req.wdata[arfc_pkg::CTL_CFG]) o_cfg_word <= i_reg_req.wdata[15:0];
    end
  end
  // Rate timer: one start event every div_q base clocks while running.
  assign tick = running_q && (rate_cnt_q == 32'h0000_0000);
  assign start_event = go_q || tick;
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      running_q <= 1'b0;
      rate_cnt_q <= 32'h0000_0000;
    end else if (wr_div && i_reg_req.wdata == 32'h0000_0000) begin
      running_q <= 1'b0;
    end else if (go_q && wide) begin
      running_q <= 1'b1;
      rate_cnt_q <= div_q - 32'h0000_0001;
    end else if (running_q) begin
      rate_cnt_q <= tick ? div_q - 32'h0000_0001 : rate_cnt_q - 32'h0000_0001;
    end
  end
  // Start sequencer; a start event during a scan in progress is dropped.
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      seq_q <= arfc_pkg::SEQ_IDLE;
      o_conv_start <= 1'b0;
      o_conv_channel <= 3'h0;
      scan_ch_q <= 3'h0;
      gap_cnt_q <= 32'h0000_0000;
      pins_q <= 2'h0;
    end else begin
      o_conv_start <= 1'b0;
      case (seq_q)
        arfc_pkg::SEQ_IDLE: begin
          if (start_event) begin
            o_conv_start <= 1'b1;
            pins_q <= i_pin_snapshot;
            if (ctrl_q[arfc_pkg::CTL_SCAN] && ctrl_q[arfc_pkg::CTL_LAST_LO +: 3] != 3'h0) begin
              o_conv_channel <= 3'h0;
              scan_ch_q <= 3'h1;
              gap_cnt_q <= div2_q;
              seq_q <= arfc_pkg::SEQ_SCAN;
            end else begin
              o_conv_channel <= ctrl_q[arfc_pkg::CTL_LAST_LO +: 3];
            end
          end
        end
        arfc_pkg::SEQ_SCAN: begin
          if (gap_cnt_q <= 32'h0000_0001) begin
            o_conv_start <= 1'b1;
            pins_q <= i_pin_snapshot;
            o_conv_channel <= scan_ch_q;
            scan_ch_q <= scan_ch_q + 3'h1;
            gap_cnt_q <= div2_q;
            if (scan_ch_q == ctrl_q[arfc_pkg::CTL_LAST_LO +: 3]) seq_q <= arfc_pkg::SEQ_IDLE;
          end else begin
            gap_cnt_q <= gap_cnt_q - 32'h0000_0001;
          end
        end
        default: seq_q <= arfc_pkg::SEQ_IDLE;
      endcase
    end
  end
  // Two-entry skid buffer between the converter and the result buffer.
  logic [31:0] sk_mem_q [0:1];
  logic sk_wp_q, sk_rp_q, sk_push, sk_pop, acc_ready;
  logic [1:0] sk_cnt_q, sk_cnt_d;
  assign sk_push = i_smp_valid && o_smp_ready;
  assign sk_pop = (sk_cnt_q != 2'h0) && acc_ready;
  assign sk_cnt_d = sk_cnt_q + {1'b0, sk_push} - {1'b0, sk_pop};
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sk_cnt_q <= 2'h0;
      sk_wp_q <= 1'b0;
      sk_rp_q <= 1'b0;
      o_smp_ready <= 1'b1;
      sk_mem_q[0] <= 32'h0000_0000;
      sk_mem_q[1] <= 32'h0000_0000;
    end else begin
      if (sk_push) begin
        sk_mem_q[sk_wp_q] <= build_word(i_smp, pins_q, running_q);
        sk_wp_q <= ~sk_wp_q;
      end
      if (sk_pop) sk_rp_q <= ~sk_rp_q;
      sk_cnt_q <= sk_cnt_d;
      o_smp_ready <= sk_cnt_d != 2'h2;
    end
  end
  // Result buffer pointers, pairing and count.
  logic [AW-1:0] wp_q, rp_q, cnt_q;
  logic [31:0] hold_q;
  logic hold_v_q, half_q, empty, full, mem_we, pop, dma_take;
  logic [63:0] mem_wdata, mem_q;
  assign empty = cnt_q == {AW{1'b0}};
  assign full = cnt_q == MAX_CNT;
  assign acc_ready = (wide && !hold_v_q) || !full;
  assign mem_we = sk_pop && (!wide || hold_v_q) && !wr_div;
  assign mem_wdata = wide ? {sk_mem_q[sk_rp_q], hold_q} : {32'h0000_0000, sk_mem_q[sk_rp_q]};
  assign dma_take = i_dma_req && !host_rd_data && !empty && !wr_div;
  assign pop = ((host_rd_data && !empty && (!wide || half_q)) || dma_take) && !wr_div;
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {AW{1'b0}};
      hold_q <= 32'h0000_0000;
      hold_v_q <= 1'b0;
      half_q <= 1'b0;
    end else if (wr_div) begin
      // A mode change empties the buffer so that entry widths never mix.
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {AW{1'b0}};
      hold_v_q <= 1'b0;
      half_q <= 1'b0;
    end else begin
      if (sk_pop && wide && !hold_v_q) begin
        hold_q <= sk_mem_q[sk_rp_q];
        hold_v_q <= 1'b1;
      end else if (mem_we) begin
        hold_v_q <= 1'b0;
      end
      if (mem_we) wp_q <= wp_q + {{(AW-1){1'b0}}, 1'b1};
      if (pop) rp_q <= rp_q + {{(AW-1){1'b0}}, 1'b1};
      cnt_q <= cnt_q + {{(AW-1){1'b0}}, mem_we} - {{(AW-1){1'b0}}, pop};
      if (dma_take) half_q <= 1'b0;
      else if (host_rd_data && !empty && wide) half_q <= ~half_q;
    end
  end
  arfc_buffer_mem #(.WIDTH(64), .AW(AW)) u_mem (
    .i_core_clk(i_core_clk),
    .i_we(mem_we),
    .i_waddr(wp_q),
    .i_wdata(mem_wdata),
    .i_raddr(rp_q),
    .o_rdata(mem_q)
  );
  // Sticky status; a new event wins over a clear in the same cycle.
  logic clr_st;
  assign clr_st = i_reg_req.wr && hit(i_reg_req, arfc_pkg::OFS_STAT);
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_almost_full <= 1'b0;
      o_overrun <= 1'b0;
    end else begin
      if (32'(cnt_q) >= {20'h00000, thr_q}) o_almost_full <= 1'b1;
      else if (clr_st && i_reg_req.wdata[arfc_pkg::STAT_AF]) o_almost_full <= 1'b0;
      if (i_smp_valid && !o_smp_ready) o_overrun <= 1'b1;
      else if (clr_st && i_reg_req.wdata[arfc_pkg::STAT_OVR]) o_overrun <= 1'b0;
    end
  end
  // Read pipeline: stage one decodes and pops, stage two picks up the memory output.
  logic rd_v_q, rd_data_q, rd_inv_q, rd_hi_q, dma_v_q;
  logic [31:0] rd_other_q, rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (i_reg_req.addr)
      arfc_pkg::OFS_DIV: rd_mux = div_q;
      arfc_pkg::OFS_DIV2: rd_mux = div2_q;
      arfc_pkg::OFS_THR: rd_mux = {20'h00000, thr_q};
      arfc_pkg::OFS_CNT: rd_mux = 32'(cnt_q);
      arfc_pkg::OFS_CTRL: rd_mux = ctrl_q;
      arfc_pkg::OFS_STAT: begin
        rd_mux[arfc_pkg::STAT_AF] = o_almost_full;
        rd_mux[arfc_pkg::STAT_OVR] = o_overrun;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rd_v_q <= 1'b0;
      rd_data_q <= 1'b0;
      rd_inv_q <= 1'b0;
      rd_hi_q <= 1'b0;
      dma_v_q <= 1'b0;
      rd_other_q <= 32'h0000_0000;
      o_reg_rvalid <= 1'b0;
      o_reg_rdata <= 32'h0000_0000;
      o_dma_valid <= 1'b0;
      o_dma_data <= 64'h0000_0000_0000_0000;
    end else begin
      rd_v_q <= i_reg_req.rd;
      rd_data_q <= host_rd_data;
      rd_inv_q <= empty;
      rd_hi_q <= wide && half_q;
      dma_v_q <= dma_take;
      rd_other_q <= rd_mux;
      o_reg_rvalid <= rd_v_q;
      o_dma_valid <= dma_v_q;
      if (dma_v_q) o_dma_data <= mem_q;
      if (rd_data_q) begin
        o_reg_rdata <= rd_inv_q ? arfc_pkg::INVALID_WORD :
                       (rd_hi_q ? mem_q[63:32] : mem_q[31:0]);
      end else begin
        o_reg_rdata <= rd_other_q;
      end
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_answer; ##2 o_reg_rvalid; endsequence
  sequence s_thr_wr; i_reg_req.wr && hit(i_reg_req, arfc_pkg::OFS_THR); endsequence
  property p_thr; s_thr_wr |=> thr_q == $past(i_reg_req.wdata[11:0]); endproperty
  a_thr: assert property (p_thr) else $error("threshold not stored");
  property p_narrow; mem_we && !wide |-> mem_wdata[63:32] == 32'h0000_0000; endproperty
  a_narrow: assert property (p_narrow) else $error("narrow entry upper half set");
  property p_pair;
    sk_pop && wide && !hold_v_q && !wr_div |=> hold_v_q && $stable(wp_q);
  endproperty
  a_pair: assert property (p_pair) else $error("first half not held");
  property p_cnt_rd;
    i_reg_req.rd && hit(i_reg_req, arfc_pkg::OFS_CNT) |-> s_answer ##0 o_reg_rdata[31:12] == 20'h0;
  endproperty
  a_cnt_rd: assert property (p_cnt_rd) else $error("count read malformed");
  property p_half;
    host_rd_data && !empty && wide && !half_q && !wr_div |=> half_q && $stable(rp_q);
  endproperty
  a_half: assert property (p_half) else $error("first half read popped entry");
  property p_invalid;
    host_rd_data && empty |-> s_answer ##0 o_reg_rdata[arfc_pkg::W_INVALID];
  endproperty
  a_invalid: assert property (p_invalid) else $error("empty read not invalid");
  property p_single;
    go_q && !wide && seq_q == arfc_pkg::SEQ_IDLE && !ctrl_q[arfc_pkg::CTL_SCAN]
      |=> o_conv_start ##1 (!o_conv_start && !running_q) [*3];
  endproperty
  a_single: assert property (p_single) else $error("single launch misbehaved");
  property p_cfg;
    wr_ctrl && i_reg_req.wdata[arfc_pkg::CTL_CFG]
      |=> o_cfg_strobe && o_cfg_word == $past(i_reg_req.wdata[15:0]) ##1 !o_cfg_strobe;
  endproperty
  a_cfg: assert property (p_cfg) else $error("settings push wrong");
  property p_ovr; i_smp_valid && !o_smp_ready |=> o_overrun; endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not latched");
  property p_af; 32'(cnt_q) >= {20'h00000, thr_q} |=> o_almost_full; endproperty
  a_af: assert property (p_af) else $error("almost full not latched");
endmodule : arfc_top

/* File: sim/arfc_conv_model.sv */
// Behavioural converter facing the result buffer.
// Assumes one start pulse per conversion; each result is held until taken.
`timescale 1ns/10ps
module arfc_conv_model (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_start,
  input wire logic [2:0] i_channel,
  input wire logic [3:0] i_lat,
  input wire logic i_ready,
  output logic o_valid,
  output arfc_pkg::arfc_sample_t o_smp
);
  logic busy_q;
  logic [3:0] cnt_q;
  logic [2:0] ch_q;
  logic [15:0] seq_q;

  // Idle data lines toggle every cycle so a stale word never looks valid.
  // A start that comes while a result is still offered is dropped, as on real parts.
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      busy_q <= 1'b0;
      cnt_q <= 4'h0;
      ch_q <= 3'h0;
      seq_q <= 16'h8000;
      o_valid <= 1'b0;
      o_smp <= '0;
    end else if (o_valid) begin
      if (i_ready) begin
        o_valid <= 1'b0;
        o_smp <= ~o_smp;
      end
    end else if (busy_q && cnt_q == 4'h0) begin
      busy_q <= 1'b0;
      o_valid <= 1'b1;
      o_smp <= {ch_q[1], ch_q[2], ch_q[0], ch_q, ch_q[0], ch_q, seq_q};
      seq_q <= seq_q + 16'h1;
    end else begin
      o_smp <= ~o_smp;
      if (busy_q) begin
        cnt_q <= cnt_q - 4'h1;
      end
      if (i_start) begin
        busy_q <= 1'b1;
        cnt_q <= i_lat;
        ch_q <= i_channel;
      end
    end
  end
endmodule : arfc_conv_model

/* File: sim/testbench.sv */
// Self-checking bench for the acquisition result buffer and its control.
// Assumes the converter model on the far side; depth shortened to 15 entries.
`timescale 1ns/10ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; \
  $display("Error %s exp %h got %h", n, e, a); end end
module testbench;
  logic i_core_clk = 1'b0;
  logic i_nrst = 1'b0;
  arfc_pkg::arfc_reg_req_t req = '0;
  arfc_pkg::arfc_sample_t smp;
  logic [31:0] rdata;
  logic [63:0] dma_data;
  logic [15:0] cfg_word;
  logic [2:0] conv_ch;
  logic [1:0] pins = 2'b10;
  logic [3:0] lat = 4'h3;
  logic [15:0] res = 16'h8000;
  logic rvalid, dma_valid, smp_valid, smp_ready, conv_start, cfg_strobe, af, ovr;
  logic dma_req = 1'b0;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  int nstart = 0;
  int st_t[$];
  logic [2:0] st_ch[$];

  arfc_top #(.AW(4)) u_dut (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_reg_req(req),
    .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_dma_req(dma_req), .o_dma_data(dma_data),
    .o_dma_valid(dma_valid), .i_smp_valid(smp_valid), .i_smp(smp), .o_smp_ready(smp_ready),
    .i_pin_snapshot(pins), .o_conv_start(conv_start), .o_conv_channel(conv_ch),
    .o_cfg_word(cfg_word), .o_cfg_strobe(cfg_strobe), .o_almost_full(af), .o_overrun(ovr));
  arfc_conv_model u_conv (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_start(conv_start),
    .i_channel(conv_ch), .i_lat(lat), .i_ready(smp_ready), .o_valid(smp_valid), .o_smp(smp));

  initial begin
    forever #2 i_core_clk = ~i_core_clk;
  end

  always @(posedge i_core_clk) begin
    cyc++;
    if (conv_start === 1'b1) begin
      nstart++;
      st_t.push_back(cyc);
      st_ch.push_back(conv_ch);
    end
  end

  function automatic logic [31:0] exp_w(input logic [2:0] c, input logic [1:0] p,
      input logic r, input logic [15:0] v);
    return {1'b0, r, p, 2'b00, c[1], c[2], c[0], c, c[0], c, v};
  endfunction : exp_w

  task automatic finish_test();
    $display("Comparisons %0d, errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge i_core_clk);
    req = '{1'b1, 1'b0, a, d};
    @(negedge i_core_clk);
    req.wr = 1'b0;
  endtask : wr

  // The answer comes two cycles after the request edge, as one-cycle pulse.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge i_core_clk);
    req = '{1'b0, 1'b1, a, 32'h0};
    @(negedge i_core_clk);
    req.rd = 1'b0;
    @(negedge i_core_clk);
    `CHK("rvalid", 1'b1, rvalid)
    d = rdata;
  endtask : rd

  task automatic wait_cnt(input logic [31:0] n);
    logic [31:0] c;
    for (int i = 0; i < 300; i++) begin
      rd(arfc_pkg::OFS_CNT, c);
      if (c === n) return;
    end
    `CHK("count wait", n, c)
    finish_test();
  endtask : wait_cnt

  task automatic t_regs();
    logic [31:0] d;
    `CHK("ready", 1'b1, smp_ready)
    `CHK("overrun", 1'b0, ovr)
    rd(arfc_pkg::OFS_DATA, d);
    `CHK("empty word", 1'b1, d[31])
    `CHK("af at zero threshold", 1'b1, af)
    rd(arfc_pkg::OFS_CNT, d);
    `CHK("count", 32'h0, d)
    wr(arfc_pkg::OFS_THR, 32'hffff_ffff);
    rd(arfc_pkg::OFS_THR, d);
    `CHK("threshold", 32'h0000_0fff, d)
    wr(arfc_pkg::OFS_CNT, 32'h5);
    rd(arfc_pkg::OFS_CNT, d);
    `CHK("count ro", 32'h0, d)
    rd(8'h0c, d);
    `CHK("unmapped", 32'h0, d)
    wr(arfc_pkg::OFS_CTRL, 32'hfffc_ffff);
    rd(arfc_pkg::OFS_CTRL, d);
    `CHK("control", 32'h0004_7bfa, d)
    wr(arfc_pkg::OFS_CTRL, 32'h0);
  endtask : t_regs

  task automatic t_single();
    logic [31:0] d;
    int n0;
    n0 = nstart;
    wr(arfc_pkg::OFS_CTRL, 32'h0003_50f3);
    `CHK("cfg strobe", 1'b1, cfg_strobe)
    `CHK("cfg word", 16'h50f3, cfg_word)
    wait_cnt(1);
    `CHK("starts", n0 + 1, nstart)
    `CHK("start ch", 3'd5, st_ch[$])
    rd(arfc_pkg::OFS_CTRL, d);
    `CHK("control", 32'h0000_50f2, d)
    rd(arfc_pkg::OFS_DATA, d);
    `CHK("word", exp_w(3'd5, 2'b10, 1'b0, res), d)
    res++;
    rd(arfc_pkg::OFS_CNT, d);
    `CHK("count", 32'h0, d)
  endtask : t_single

  task automatic t_scan();
    logic [31:0] d;
    lat = 4'h0;
    wr(arfc_pkg::OFS_DIV2, 32'h3);
    wr(arfc_pkg::OFS_CTRL, 32'h0005_3000);
    wait_cnt(4);
    `CHK("scan gap", 3, st_t[$] - st_t[$-1])
    for (int i = 0; i < 4; i++) begin
      `CHK("scan ch", 3'(i), st_ch[st_ch.size() - 4 + i])
      rd(arfc_pkg::OFS_DATA, d);
      `CHK("scan word", exp_w(3'(i), 2'b10, 1'b0, res), d)
      res++;
    end
  endtask : t_scan

  task automatic t_wide();
    logic [31:0] d;
    logic [63:0] e;
    pins = 2'b01;
    lat = 4'h7;
    wr(arfc_pkg::OFS_DIV, 32'd200);
    wr(arfc_pkg::OFS_CTRL, 32'h0001_2000);
    wait_cnt(1);
    `CHK("rate", 200, st_t[$] - st_t[$-1])
    rd(arfc_pkg::OFS_DATA, d);
    `CHK("low word", exp_w(3'd2, 2'b01, 1'b1, res), d)
    rd(arfc_pkg::OFS_CNT, d);
    `CHK("half read", 32'h1, d)
    rd(arfc_pkg::OFS_DATA, d);
    `CHK("high word", exp_w(3'd2, 2'b01, 1'b1, res + 16'h1), d)
    rd(arfc_pkg::OFS_CNT, d);
    `CHK("count", 32'h0, d)
    res += 16'h2;
    wait_cnt(1);
    @(negedge i_core_clk);
    dma_req = 1'b1;
    @(negedge i_core_clk);
    dma_req = 1'b0;
    @(negedge i_core_clk);
    `CHK("dma valid", 1'b1, dma_valid)
    e = {exp_w(3'd2, 2'b01, 1'b1, res + 16'h1), exp_w(3'd2, 2'b01, 1'b1, res)};
    `CHK("dma data", e, dma_data)
    rd(arfc_pkg::OFS_CNT, d);
    `CHK("count", 32'h0, d)
  endtask : t_wide

  task automatic t_ovr();
    logic [31:0] d;
    int n0;
    lat = 4'h0;
    wr(arfc_pkg::OFS_DIV, 32'h0);
    repeat (20) @(negedge i_core_clk);
    // A second divisor write flushes any result that was still in flight.
    wr(arfc_pkg::OFS_DIV, 32'h0);
    wr(arfc_pkg::OFS_THR, 32'h3);
    wr(arfc_pkg::OFS_STAT, 32'h0030_0000);
    for (int i = 1; i <= 18; i++) begin
      n0 = nstart;
      wr(arfc_pkg::OFS_CTRL, 32'h0001_0000);
      if (i <= 15) begin
        wait_cnt(32'(i));
        `CHK("almost full", i >= 3, af)
      end else begin
        for (int k = 0; k < 40 && nstart == n0; k++) @(negedge i_core_clk);
        repeat (8) @(negedge i_core_clk);
        `CHK("overrun start", n0 + 1, nstart)
        `CHK("overrun", i == 18, ovr)
      end
    end
    rd(arfc_pkg::OFS_STAT, d);
    `CHK("status", 2'b11, d[21:20])
    rd(arfc_pkg::OFS_CNT, d);
    `CHK("full count", 32'd15, d)
  endtask : t_ovr

  initial begin
    repeat (2) @(negedge i_core_clk);
    i_nrst = 1'b1;
    t_regs();
    t_single();
    t_scan();
    t_wide();
    t_ovr();
    finish_test();
  end
endmodule : testbench
